// File: logic/bsc_pkg.sv
package bsc_pkg;
    localparam int INSTR_W = 14;
    localparam int PC_W = 10;
    localparam int FADDR_W = 7;
    localparam int BIT_FADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int STACK_DEPTH = 8;
    localparam int STACK_IDX_W = 3;
    // Opcode match patterns, NOP word, reset PC and clear value
    localparam logic [4:0] OP_SKIP_CLR = 5'h0a;
    localparam logic [4:0] OP_SKIP_SET = 5'h0b;
    localparam logic [3:0] OP_CALL = 4'h8;
    localparam logic [6:0] OP_CLEAR_FILE = 7'h03;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    localparam logic [PC_W-1:0] PC_RESET = 10'h000;
    localparam logic [DATA_W-1:0] CLEAR_VALUE = 8'h00;
    // Field positions
    localparam int BIT_IDX_LSB = 6;
    localparam int CALL_OP_LSB = 10;
    localparam int SKIP_OP_LSB = 9;
    localparam int CLEAR_OP_LSB = 7;

    typedef enum logic [1:0] {
        BSC_EXEC = 2'b00,
        BSC_SECOND = 2'b01
    } bsc_state_t;

    typedef struct packed {
        logic we;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bsc_file_wr_t;

    typedef struct packed {
        logic skip_clr;
        logic skip_set;
        logic call;
        logic clear_file;
        logic [2:0] bit_idx;
        logic [FADDR_W-1:0] faddr;
        logic [PC_W-1:0] target;
    } bsc_decode_t;
endpackage

// File: logic/bsc_stack.sv
`timescale 1ns/1ps
`default_nettype none
// Circular return stack; overflow overwrites the oldest entry
module bsc_stack (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Push
    input wire logic push,
    input wire logic [bsc_pkg::PC_W-1:0] push_addr,
    // Top
    output logic [bsc_pkg::PC_W-1:0] stack_top
);
    logic [bsc_pkg::PC_W-1:0] mem_r [bsc_pkg::STACK_DEPTH];
    logic [bsc_pkg::STACK_IDX_W-1:0] ptr_r;
    logic [bsc_pkg::STACK_IDX_W-1:0] top_idx;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ptr_r <= '0;
        end else if (push) begin
            ptr_r <= ptr_r + 3'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < bsc_pkg::STACK_DEPTH; i++) begin
                mem_r[i] <= bsc_pkg::PC_RESET;
            end
        end else if (push) begin
            mem_r[ptr_r] <= push_addr;
        end
    end

    // Top is the entry written by the latest push
    assign top_idx = ptr_r - 3'd1;
    assign stack_top = mem_r[top_idx];

    push_top_a: assert property (@(posedge sys_clk) disable iff (srst)
        push |=> stack_top == $past(push_addr))
        else $error("stack top not pushed value");
    wrap_ptr_a: assert property (@(posedge sys_clk) disable iff (srst)
        push && ptr_r == 3'd7 |=> ptr_r == 3'd0)
        else $error("stack pointer did not wrap");
endmodule // bsc_stack
`default_nettype wire

// File: logic/bsc_exec.sv
`timescale 1ns/1ps
`default_nettype none
module bsc_exec (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Fetch path
    input wire logic [bsc_pkg::INSTR_W-1:0] instr,
    output logic [bsc_pkg::PC_W-1:0] pc,
    // Register file
    output logic [bsc_pkg::FADDR_W-1:0] rd_addr,
    input wire logic [bsc_pkg::DATA_W-1:0] rd_data,
    output bsc_pkg::bsc_file_wr_t file_wr,
    // Status
    output logic zero_set,
    output logic busy,
    // Return stack
    output logic [bsc_pkg::PC_W-1:0] stack_top
);
    function automatic bsc_pkg::bsc_decode_t decode(
        input logic [bsc_pkg::INSTR_W-1:0] w);
        bsc_pkg::bsc_decode_t d;
        d = '0;
        d.skip_clr = w[13:bsc_pkg::SKIP_OP_LSB] == bsc_pkg::OP_SKIP_CLR;
        d.skip_set = w[13:bsc_pkg::SKIP_OP_LSB] == bsc_pkg::OP_SKIP_SET;
        d.call = w[13:bsc_pkg::CALL_OP_LSB] == bsc_pkg::OP_CALL;
        d.clear_file = w[13:bsc_pkg::CLEAR_OP_LSB] == bsc_pkg::OP_CLEAR_FILE;
        d.bit_idx = w[8:bsc_pkg::BIT_IDX_LSB];
        d.faddr = d.clear_file ? w[6:0] : {1'b0, w[5:0]};
        d.target = w[bsc_pkg::PC_W-1:0];
        return d;
    endfunction

    function automatic logic is_test(input bsc_pkg::bsc_decode_t d);
        return d.skip_clr || d.skip_set;
    endfunction

    bsc_pkg::bsc_state_t state_r;
    bsc_pkg::bsc_decode_t dec;
    logic [bsc_pkg::INSTR_W-1:0] word;
    logic [bsc_pkg::PC_W-1:0] pc_plus1;
    logic bit_val;
    logic skip_take;
    logic push;
    logic hold_pc_r;

    // Second cycle of a skip or call executes a NOP
    assign word = (state_r == bsc_pkg::BSC_SECOND) ?
        bsc_pkg::NOP_WORD : instr;
    assign dec = decode(word);
    assign rd_addr = dec.faddr;
    assign bit_val = rd_data[dec.bit_idx];
    assign skip_take = (dec.skip_clr && !bit_val)
        || (dec.skip_set && bit_val);
    assign pc_plus1 = pc + 10'd1;
    assign push = dec.call;
    assign busy = state_r == bsc_pkg::BSC_SECOND;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= bsc_pkg::BSC_EXEC;
        end else if (state_r == bsc_pkg::BSC_EXEC &&
            (skip_take || dec.call)) begin
            state_r <= bsc_pkg::BSC_SECOND;
        end else begin
            state_r <= bsc_pkg::BSC_EXEC;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pc <= bsc_pkg::PC_RESET;
        end else if (dec.call) begin
            pc <= dec.target;
        end else if (hold_pc_r) begin
            pc <= pc;
        end else begin
            pc <= pc_plus1;
        end
    end

    // Call's NOP cycle keeps the target so the subroutine's first word runs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_pc_r <= 1'b0;
        end else begin
            hold_pc_r <= dec.call;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            file_wr <= '0;
        end else begin
            file_wr.we <= dec.clear_file;
            file_wr.addr <= dec.faddr;
            file_wr.data <= bsc_pkg::CLEAR_VALUE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            zero_set <= 1'b0;
        end else begin
            zero_set <= dec.clear_file;
        end
    end

    bsc_stack u_stack (
        .sys_clk(sys_clk),
        .srst(srst),
        .push(push),
        .push_addr(pc_plus1),
        .stack_top(stack_top)
    );

    sequence call_seq;
        !busy && dec.call;
    endsequence

    sequence clr_take_seq;
        !busy && dec.skip_clr && !bit_val;
    endsequence

    sequence set_take_seq;
        !busy && dec.skip_set && bit_val;
    endsequence

    sequence test_stay_seq;
        !busy && is_test(dec) && !skip_take;
    endsequence

    sequence clear_seq;
        !busy && dec.clear_file;
    endsequence

    sequence nop_cycle_seq;
        busy ##1 !busy;
    endsequence

    // Call: target, return address, two cycles
    call_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> pc == $past(dec.target))
        else $error("call target not loaded");
    call_push_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> stack_top == $past(pc) + 10'd1)
        else $error("return address wrong");
    call_two_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> busy ##1 !busy)
        else $error("call not two cycles");
    call_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> !zero_set)
        else $error("call touched flags");
    call_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> ##1 pc == $past(pc))
        else $error("call target not held");
    call_top_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> ##1 $stable(stack_top))
        else $error("stack top moved in NOP cycle");
    call_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
        call_seq |=> !zero_set ##1 (!zero_set && !file_wr.we))
        else $error("call had side effects");

    // Bit tests: skip decision and timing; clear register write
    clr_skip_a: assert property (@(posedge sys_clk) disable iff (srst)
        clr_take_seq |=> nop_cycle_seq)
        else $error("clear test did not skip");
    set_skip_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy && dec.skip_set && !bit_val |=> !busy)
        else $error("set test skipped on 0");
    set_take_a: assert property (@(posedge sys_clk) disable iff (srst)
        set_take_seq |=> nop_cycle_seq)
        else $error("set test did not skip");
    clr_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy && dec.skip_clr && bit_val |=> !busy)
        else $error("clear test skipped on 1");
    skip_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy && skip_take |=> (pc == $past(pc) + 10'd1)
        ##1 (pc == $past(pc) + 10'd1))
        else $error("skip did not pass next word");
    test_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
        test_stay_seq |=> !busy && pc == $past(pc) + 10'd1)
        else $error("test without skip not one cycle");
    test_addr_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy && is_test(dec) |-> rd_addr == {1'b0, instr[5:0]})
        else $error("bit test address wrong");
    busy_once_a: assert property (@(posedge sys_clk) disable iff (srst)
        busy |=> !busy)
        else $error("NOP cycle longer than one");
    skip_nop_a: assert property (@(posedge sys_clk) disable iff (srst)
        busy |-> (!push && !dec.clear_file && !skip_take)
        ##1 (!file_wr.we && !zero_set))
        else $error("skipped word executed");
    clear_wr_a: assert property (@(posedge sys_clk) disable iff (srst)
        !busy && dec.clear_file |=> file_wr.we && file_wr.data == 8'h00
        && file_wr.addr == $past(word[6:0]) && zero_set && !busy)
        else $error("clear register wrong");
    test_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        dec.skip_clr || dec.skip_set |=> !zero_set)
        else $error("bit test touched flags");

    // Clear: write, flag, one cycle
    clear_pc_a: assert property (@(posedge sys_clk) disable iff (srst)
        clear_seq |=> pc == $past(pc) + 10'd1)
        else $error("clear not one cycle");
    zero_only_a: assert property (@(posedge sys_clk) disable iff (srst)
        zero_set |-> $past(dec.clear_file))
        else $error("zero flag set without clear");
    wr_only_a: assert property (@(posedge sys_clk) disable iff (srst)
        file_wr.we |-> $past(dec.clear_file)
        && file_wr.data == bsc_pkg::CLEAR_VALUE)
        else $error("register write without clear");
endmodule // bsc_exec
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [13:0] instr = 14'h0000;
    logic [7:0] rd_data = 8'h00;
    logic [9:0] pc;
    logic [6:0] rd_addr;
    bsc_pkg::bsc_file_wr_t file_wr;
    logic zero_set;
    logic busy;
    logic [9:0] stack_top;
    logic [9:0] e_pc = 10'h000;
    logic [9:0] e_top = 10'h000;
    logic e_busy = 1'b0;
    logic e_clr = 1'b0;
    logic [6:0] e_addr = 7'h00;
    logic e_hold = 1'b0;
    int errors = 0;
    int checked = 0;

    always #12.5 sys_clk = ~sys_clk;

    bsc_exec dut (
        .sys_clk(sys_clk),
        .srst(srst),
        .instr(instr),
        .pc(pc),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .file_wr(file_wr),
        .zero_set(zero_set),
        .busy(busy),
        .stack_top(stack_top)
    );

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (!ok) begin
            errors++;
            $display("Error %0t: %s", $time, msg);
        end
    endtask

    task automatic rst(input int n);
        srst = 1'b1;
        repeat (n) @(negedge sys_clk);
        chk({pc, busy, stack_top, zero_set, file_wr.we} === 23'h0, "reset");
        e_pc = 10'h000;
        e_top = 10'h000;
        e_busy = 1'b0;
        e_clr = 1'b0;
        e_hold = 1'b0;
        srst = 1'b0;
    endtask

    // Drive one word at a falling edge, predict, check a cycle later
    task automatic step(input logic [13:0] w, input logic [7:0] d);
        logic hit;
        logic skip;
        instr = w;
        rd_data = d;
        #1;
        skip = !e_busy && w[13:10] == 4'h5;
        hit = skip && (d[w[8:6]] == w[9]);
        if (skip) chk(rd_addr === {1'b0, w[5:0]}, "bit addr");
        e_clr = !e_busy && w[13:7] == 7'h03;
        if (e_clr) chk(rd_addr === w[6:0], "clear addr");
        e_addr = w[6:0];
        if (!e_busy && w[13:10] == 4'h8) begin
            e_top = e_pc + 10'h001;
            e_pc = w[9:0];
            e_busy = 1'b1;
            e_hold = 1'b1;
        end else begin
            // Call's NOP cycle keeps pc at the target
            if (!e_hold) e_pc = e_pc + 10'h001;
            e_hold = 1'b0;
            e_busy = hit;
        end
        @(negedge sys_clk);
        chk(pc === e_pc, "pc");
        chk(busy === e_busy, "busy");
        chk(stack_top === e_top, "stack_top");
        chk(zero_set === e_clr, "zero_set");
        chk(file_wr.we === e_clr, "write");
        if (e_clr) chk(file_wr === {1'b1, e_addr, 8'h00}, "clear");
    endtask

    function automatic logic [13:0] pick(input int k);
        logic [6:0] f;
        f = 7'($urandom_range(0, 95));
        case (k)
            0: pick = {5'h0a, 9'($urandom)};
            1: pick = {5'h0b, 9'($urandom)};
            2: pick = {4'h8, 10'($urandom)};
            3: pick = {7'h03, f};
            default: pick = {2'b11, 12'($urandom)};
        endcase
    endfunction

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(96));
        rst(10);
        step(14'h23ff, 8'h00);
        step(14'h2000, 8'h00);
        step(14'h15ff, 8'h7f);
        step(14'h15ff, 8'h80);
        step(14'h1600, 8'h01);
        step(14'h1600, 8'hfe);
        step(14'h01df, 8'h00);
        step(14'h0180, 8'hff);
        repeat (1000) step(pick($urandom_range(0, 4)), 8'($urandom));
        rst(1);
        repeat (1000) step(pick($urandom_range(0, 4)), 8'($urandom));
        results();
    end
endmodule // tb_top
`default_nettype wire
